// ==== shared/cod_pkg.sv ====
// Notes on behaviour
// - Mode field: 00 biphase, 01 unused, 10 normal mode 1, 11 normal mode 2.
// - Internally a dominant bit is zero and a recessive bit is one.
// - Biphase toggle flop flips per dominant bit; first dominant bit leaves on pin 0.
// - Biphase turns every driver on both pins off for the whole recessive bit.
// - Normal mode 1 drives the same untoggled bit stream on both pins.
// - Normal mode 2 sends the stream on pin 0 and the bit clock on pin 1.
// - Bit clock is high for one quantum during the synchronisation segment.
// - Each pin's high-side enable gates whether its high-side driver can turn on.
// - Each pin's low-side enable gates whether its low-side driver can turn on.
// - High side on when enabled and data XOR polarity is one; low side when zero.
// - Transmit identifier is 11 bits, MSB first, smaller value wins arbitration.
// - Upper eight identifier bits in their own register, lowest three in bits 7..5.
// - Bit 4 of frame-type/length selects remote frame when set, data frame when clear.
// - Remote frames ignore the length code and carry zero data bytes.
// - Data length code gives the byte count in plain binary, 0 to 8.
// - Eight transmit data bytes at consecutive addresses; only the counted ones are sent.
// - Receive identifier uses transmit layout; two receive buffers alternate internally.
// - Accepted message stored in order into a free buffer; none free signals overrun.
// - Received frame-type/length sits at 0x35, received data bytes at 0x36 to 0x3d.
`default_nettype none

package cod_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ODC       = 6'h28;
  localparam logic [5:0] IDX_TX_ID_HI  = 6'h2a;
  localparam logic [5:0] IDX_TX_CTL    = 6'h2b;
  localparam logic [5:0] IDX_TX_DATA0  = 6'h2c;
  localparam logic [5:0] IDX_TX_DATA7  = 6'h33;
  localparam logic [5:0] IDX_RX_ID_HI  = 6'h34;
  localparam logic [5:0] IDX_RX_CTL    = 6'h35;
  localparam logic [5:0] IDX_RX_DATA7  = 6'h3d;
  localparam logic [5:0] IDX_RX_STATUS = 6'h3e;

  // Output driver control fields
  localparam int unsigned ODC_MODE_LSB = 0;
  localparam int unsigned ODC_POL0     = 2;
  localparam int unsigned ODC_LS0      = 3;
  localparam int unsigned ODC_HS0      = 4;
  localparam int unsigned ODC_POL1     = 5;
  localparam int unsigned ODC_LS1      = 6;
  localparam int unsigned ODC_HS1      = 7;

  localparam logic [1:0] MODE_BIPHASE = 2'h0;
  localparam logic [1:0] MODE_UNUSED  = 2'h1;
  localparam logic [1:0] MODE_NORMAL1 = 2'h2;
  localparam logic [1:0] MODE_NORMAL2 = 2'h3;

  // Frame-type and length fields
  localparam int unsigned CTL_ID_LSB = 5;
  localparam int unsigned CTL_REMOTE = 4;
  localparam logic [3:0]  DLC_MAX    = 4'h8;

  // Receive status fields
  localparam int unsigned STAT_READY = 0;
  localparam int unsigned STAT_OVR   = 1;
  localparam int unsigned STAT_BOTH  = 2;

  // Buffer sizes
  localparam int unsigned TX_BYTES  = 8;
  localparam int unsigned RX_LEN    = 10;
  localparam logic [3:0]  RX_LAST_IDX = 4'h9;

  // Values after reset
  localparam logic [7:0] ODC_RST   = 8'h00;
  localparam logic       PHASE_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cod_pkg

`default_nettype wire

// ==== verilog/cod_top.sv ====
`default_nettype none

module cod_top
  import cod_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller state
  input  wire logic        reset_request,
  // Bit stream from bit timing
  input  wire logic        internal_tx_bit,
  input  wire logic        sync_seg,
  // Driver transistor states
  output logic             pin0_highside_state,
  output logic             pin0_lowside_state,
  output logic             pin1_highside_state,
  output logic             pin1_lowside_state,
  // Transmit pins
  output logic             transmit_pin_0_o,
  output logic             transmit_pin_0_oe,
  output logic             transmit_pin_1_o,
  output logic             transmit_pin_1_oe,
  // Transmit frame fetch
  output logic [10:0]      tx_identifier,
  output logic             tx_remote,
  output logic [3:0]       tx_byte_count,
  input  wire logic [2:0]  tx_byte_idx,
  output logic [7:0]       tx_byte_data,
  // Receive store
  input  wire logic        rx_wr_valid,
  input  wire logic        rx_wr_first,
  input  wire logic        rx_wr_last,
  input  wire logic [7:0]  rx_wr_data,
  output logic             rx_overrun,
  output logic             rx_msg_ready
);

  logic [7:0]  odc_ff, tx_id_hi_ff, tx_ctl_ff, tx_byte_data_ff, tx_data_set_ff;
  logic [7:0]  tx_data_ff [TX_BYTES];
  logic [7:0]  rx_mem_ff [2][RX_LEN];
  logic [1:0]  rx_full_ff, bresp_ff, rresp_ff, hs_ff, ls_ff;
  logic [3:0]  rx_idx_ff;
  logic [31:0] rdata_ff;
  logic        rx_wr_sel_ff, rx_rd_sel_ff, rx_drop_ff, rx_ovr_ff, rx_overrun_ff;
  logic        bvalid_ff, rvalid_ff, sync_q_ff, phase_ff;

  logic        wr_take, rd_take, wr_lane, wr_err, rd_err;
  logic [5:0]  wr_idx, rd_idx;
  logic [7:0]  rd_val, fetch_ref;
  logic [2:0]  wr_tx_sel, rd_tx_sel;
  logic [3:0]  rd_rx_sel, rx_wr_pos;
  logic        we_odc, we_id, we_ctl, we_data, we_stat;
  logic        rx_release, nxt_drop, rx_store, rx_commit;
  logic        bit_start, nxt_phase, drv_act;
  logic [1:0]  mode, pin_d, nxt_hs, nxt_ls;

  // AXI4-Lite slave: both write channels are taken together, one at a time
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign rd_take       = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  assign wr_idx    = s_axi_awaddr[7:2];
  assign rd_idx    = s_axi_araddr[7:2];
  assign wr_lane   = s_axi_wstrb[0];
  assign wr_tx_sel = 3'(wr_idx - IDX_TX_DATA0);
  assign rd_tx_sel = 3'(rd_idx - IDX_TX_DATA0);
  assign rd_rx_sel = 4'(rd_idx - IDX_RX_ID_HI);

  // Write decode; receive copies are read-only and answer with an error
  always_comb begin
    we_odc  = 1'b0;
    we_id   = 1'b0;
    we_ctl  = 1'b0;
    we_data = 1'b0;
    we_stat = 1'b0;
    wr_err  = 1'b0;
    if (wr_idx == IDX_ODC) begin
      wr_err = ~reset_request;
      we_odc = reset_request;
    end else if (wr_idx == IDX_TX_ID_HI) begin
      we_id = 1'b1;
    end else if (wr_idx == IDX_TX_CTL) begin
      we_ctl = 1'b1;
    end else if (wr_idx >= IDX_TX_DATA0 && wr_idx <= IDX_TX_DATA7) begin
      we_data = 1'b1;
    end else if (wr_idx == IDX_RX_STATUS) begin
      we_stat = 1'b1;
    end else begin
      wr_err = 1'b1;
    end
  end

  // Read decode
  always_comb begin
    rd_val = 8'h00;
    rd_err = 1'b0;
    if (rd_idx == IDX_ODC) begin
      rd_err = ~reset_request;
      rd_val = reset_request ? odc_ff : 8'h00;
    end else if (rd_idx == IDX_TX_ID_HI) begin
      rd_val = tx_id_hi_ff;
    end else if (rd_idx == IDX_TX_CTL) begin
      rd_val = tx_ctl_ff;
    end else if (rd_idx >= IDX_TX_DATA0 && rd_idx <= IDX_TX_DATA7) begin
      rd_val = tx_data_ff[rd_tx_sel];
    end else if (rd_idx >= IDX_RX_ID_HI && rd_idx <= IDX_RX_DATA7) begin
      rd_val = rx_mem_ff[rx_rd_sel_ff][rd_rx_sel];
    end else if (rd_idx == IDX_RX_STATUS) begin
      rd_val[STAT_READY] = rx_full_ff[rx_rd_sel_ff];
      rd_val[STAT_OVR]   = rx_ovr_ff;
      rd_val[STAT_BOTH]  = &rx_full_ff;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_take) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      rdata_ff  <= {24'h00_0000, rd_val};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Driver setup is defined after reset so the pins start floating
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      odc_ff <= ODC_RST;
    end else if (wr_take && wr_lane && we_odc) begin
      odc_ff <= s_axi_wdata[7:0];
    end
  end

  // Transmit buffer has no reset on purpose: contents stay undefined
  always_ff @(posedge clk_sys) begin
    if (wr_take && wr_lane && we_id) begin
      tx_id_hi_ff <= s_axi_wdata[7:0];
    end
    if (wr_take && wr_lane && we_ctl) begin
      tx_ctl_ff <= s_axi_wdata[7:0];
    end
    if (wr_take && wr_lane && we_data) begin
      tx_data_ff[wr_tx_sel] <= s_axi_wdata[7:0];
    end
  end

  // Frame engine view of the transmit buffer
  assign tx_identifier = {tx_id_hi_ff, tx_ctl_ff[7:CTL_ID_LSB]};
  assign tx_remote     = tx_ctl_ff[CTL_REMOTE];

  always_comb begin
    if (tx_ctl_ff[CTL_REMOTE]) begin
      tx_byte_count = 4'h0;
    end else if (tx_ctl_ff[3:0] > DLC_MAX) begin
      tx_byte_count = DLC_MAX;
    end else begin
      tx_byte_count = tx_ctl_ff[3:0];
    end
  end

  assign fetch_ref = tx_data_ff[tx_byte_idx];

  // Marks bytes written since reset, so the fetch check skips undefined ones
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_byte_data_ff <= 8'h00;
      tx_data_set_ff  <= 8'h00;
    end else begin
      tx_byte_data_ff <= fetch_ref;
      if (wr_take && wr_lane && we_data) begin
        tx_data_set_ff[wr_tx_sel] <= 1'b1;
      end
    end
  end

  assign tx_byte_data = tx_byte_data_ff;

  // Receive side: a message is dropped whole if its buffer is still held by software
  assign nxt_drop   = rx_wr_first ? rx_full_ff[rx_wr_sel_ff] : rx_drop_ff;
  assign rx_wr_pos  = rx_wr_first ? 4'h0 : rx_idx_ff;
  assign rx_store   = rx_wr_valid & ~nxt_drop & (rx_wr_pos <= RX_LAST_IDX);
  assign rx_commit  = rx_wr_valid & rx_wr_last & ~nxt_drop;
  assign rx_release = wr_take & wr_lane & we_stat & s_axi_wdata[STAT_READY]
                      & rx_full_ff[rx_rd_sel_ff];

  always_ff @(posedge clk_sys) begin
    if (rx_store) begin
      rx_mem_ff[rx_wr_sel_ff][rx_wr_pos] <= rx_wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_idx_ff  <= 4'h0;
      rx_drop_ff <= 1'b0;
    end else if (rx_wr_valid) begin
      rx_idx_ff  <= 4'(rx_wr_pos + 4'h1);
      rx_drop_ff <= nxt_drop;
    end
  end

  // Clear first, then set, so a completing message is never lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_full_ff   <= 2'b00;
      rx_wr_sel_ff <= 1'b0;
      rx_rd_sel_ff <= 1'b0;
    end else begin
      if (rx_release) begin
        rx_full_ff[rx_rd_sel_ff] <= 1'b0;
        rx_rd_sel_ff             <= ~rx_rd_sel_ff;
      end
      if (rx_commit) begin
        rx_full_ff[rx_wr_sel_ff] <= 1'b1;
        rx_wr_sel_ff             <= ~rx_wr_sel_ff;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_ovr_ff     <= 1'b0;
      rx_overrun_ff <= 1'b0;
    end else begin
      rx_overrun_ff <= rx_wr_valid & rx_wr_first & rx_full_ff[rx_wr_sel_ff];
      if (rx_wr_valid && rx_wr_first && rx_full_ff[rx_wr_sel_ff]) begin
        rx_ovr_ff <= 1'b1;
      end else if (wr_take && wr_lane && we_stat && s_axi_wdata[STAT_OVR]) begin
        rx_ovr_ff <= 1'b0;
      end
    end
  end

  assign rx_overrun   = rx_overrun_ff;
  assign rx_msg_ready = rx_full_ff[rx_rd_sel_ff];

  // Output encoder; the bit stream uses zero for dominant
  assign mode      = odc_ff[ODC_MODE_LSB +: 2];
  assign bit_start = sync_seg & ~sync_q_ff;
  assign nxt_phase = (bit_start && mode == MODE_BIPHASE && !internal_tx_bit)
                     ? ~phase_ff : phase_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_q_ff <= 1'b0;
      phase_ff  <= PHASE_RST;
    end else begin
      sync_q_ff <= sync_seg;
      phase_ff  <= nxt_phase;
    end
  end

  always_comb begin
    unique case (mode)
      MODE_BIPHASE: begin
        drv_act = ~internal_tx_bit;
        pin_d   = {~nxt_phase, nxt_phase};
      end
      MODE_UNUSED: begin
        drv_act = 1'b0;
        pin_d   = 2'b11;
      end
      MODE_NORMAL1: begin
        drv_act = 1'b1;
        pin_d   = {internal_tx_bit, internal_tx_bit};
      end
      MODE_NORMAL2: begin
        drv_act = 1'b1;
        pin_d   = {sync_seg, internal_tx_bit};
      end
    endcase
  end

  // Transistor states per pin; never both on since the XOR picks one side
  assign nxt_hs[0] = drv_act & odc_ff[ODC_HS0] & (pin_d[0] ^ odc_ff[ODC_POL0]);
  assign nxt_ls[0] = drv_act & odc_ff[ODC_LS0] & ~(pin_d[0] ^ odc_ff[ODC_POL0]);
  assign nxt_hs[1] = drv_act & odc_ff[ODC_HS1] & (pin_d[1] ^ odc_ff[ODC_POL1]);
  assign nxt_ls[1] = drv_act & odc_ff[ODC_LS1] & ~(pin_d[1] ^ odc_ff[ODC_POL1]);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hs_ff <= 2'b00;
      ls_ff <= 2'b00;
    end else begin
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
    end
  end

  assign pin0_highside_state = hs_ff[0];
  assign pin0_lowside_state  = ls_ff[0];
  assign pin1_highside_state = hs_ff[1];
  assign pin1_lowside_state  = ls_ff[1];
  assign transmit_pin_0_o    = hs_ff[0];
  assign transmit_pin_0_oe   = hs_ff[0] | ls_ff[0];
  assign transmit_pin_1_o    = hs_ff[1];
  assign transmit_pin_1_oe   = hs_ff[1] | ls_ff[1];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_pin_no_short: assert property (!(hs_ff[0] && ls_ff[0]) && !(hs_ff[1] && ls_ff[1]))
    else $error("high and low side on together");
  a_biph_recessive: assert property (
    (mode == MODE_BIPHASE && internal_tx_bit) |=> (hs_ff == 2'b00 && ls_ff == 2'b00))
    else $error("biphase recessive bit not floating");
  a_biph_toggle: assert property (
    (bit_start && mode == MODE_BIPHASE && !internal_tx_bit) |=> phase_ff != $past(phase_ff))
    else $error("biphase flop did not toggle on dominant bit");
  a_biph_first_pin0: assert property (
    (mode == MODE_BIPHASE && !internal_tx_bit && !nxt_phase && odc_ff[ODC_LS0]
     && !odc_ff[ODC_POL0]) |=> ls_ff[0])
    else $error("dominant bit missing on pin 0");
  a_norm1_same: assert property (
    (mode == MODE_NORMAL1 && odc_ff[7:5] == odc_ff[4:2]) |=> (hs_ff[0] == hs_ff[1]
     && ls_ff[0] == ls_ff[1]))
    else $error("normal mode 1 pins differ");
  a_norm2_clock: assert property (
    (mode == MODE_NORMAL2 && odc_ff[ODC_HS1] && !odc_ff[ODC_POL1]) |=>
    (hs_ff[1] == $past(sync_seg)))
    else $error("bit clock not on pin 1");
  a_enable_gate: assert property (
    (!odc_ff[ODC_HS0] && !odc_ff[ODC_LS1]) |=> (!hs_ff[0] && !ls_ff[1]))
    else $error("disabled driver turned on");
  a_remote_count: assert property (
    tx_ctl_ff[CTL_REMOTE] |-> tx_byte_count == 4'h0)
    else $error("remote frame with data bytes");
  a_dlc_count: assert property (
    (!tx_ctl_ff[CTL_REMOTE] && tx_ctl_ff[3:0] <= DLC_MAX) |-> tx_byte_count == tx_ctl_ff[3:0])
    else $error("byte count differs from length code");
  a_tx_fetch: assert property (
    tx_data_set_ff[tx_byte_idx] |=> tx_byte_data == $past(fetch_ref))
    else $error("fetched byte wrong");
  a_rx_overrun: assert property (
    (rx_wr_valid && rx_wr_first && rx_full_ff[rx_wr_sel_ff]) |=> (rx_overrun && rx_ovr_ff))
    else $error("overrun not signalled");
  a_rx_swap: assert property (rx_commit |=> rx_wr_sel_ff != $past(rx_wr_sel_ff))
    else $error("receive buffer did not alternate");
  a_odc_lock: assert property (
    (!reset_request) |=> odc_ff == $past(odc_ff))
    else $error("driver setup changed outside reset request");

  c_biph_dominant: cover property (bit_start && mode == MODE_BIPHASE && !internal_tx_bit);
  c_norm2_clock:   cover property (mode == MODE_NORMAL2 && bit_start);
  c_rx_overrun:    cover property (rx_overrun);
  c_rx_both_full:  cover property (&rx_full_ff);

endmodule : cod_top

`default_nettype wire

// ==== verif/cod_node_model.sv ====
`default_nettype none

module cod_node_model (
  // Clock
  input  wire logic      clk_sys,
  // Bit stream towards the drivers
  output var logic       internal_tx_bit,
  output var logic       sync_seg,
  // Accepted message bytes
  output var logic       rx_wr_valid,
  output var logic       rx_wr_first,
  output var logic       rx_wr_last,
  output var logic [7:0] rx_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus rests recessive with no sync pulse
  initial begin
    internal_tx_bit = 1'b1;
    sync_seg        = 1'b0;
    rx_wr_valid     = 1'b0;
    rx_wr_first     = 1'b0;
    rx_wr_last      = 1'b0;
    rx_wr_data      = 8'h00;
  end

  // One bit of q quanta, sync segment first
  task automatic send_bit(input logic b, input int q);
    @(posedge clk_sys);
    internal_tx_bit <= b;
    sync_seg        <= 1'b1;
    @(posedge clk_sys);
    sync_seg <= 1'b0;
    repeat (q - 1) @(posedge clk_sys);
  endtask : send_bit

  // Ten bytes in order; data toggles while idle so stale values never match
  task automatic send_msg(input logic [7:0] base, input int gap);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rx_wr_valid <= 1'b1;
      rx_wr_first <= (i == 0);
      rx_wr_last  <= (i == 9);
      rx_wr_data  <= base + 8'(i);
      repeat (gap) begin
        @(posedge clk_sys);
        rx_wr_valid <= 1'b0;
        rx_wr_data  <= ~rx_wr_data;
      end
    end
    @(posedge clk_sys);
    rx_wr_valid <= 1'b0;
    rx_wr_first <= 1'b0;
    rx_wr_last  <= 1'b0;
    rx_wr_data  <= ~rx_wr_data;
  endtask : send_msg
endmodule : cod_node_model

`default_nettype wire

// ==== verif/cod_tb_top.sv ====
`default_nettype none

module cod_tb_top import cod_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, reset, reset_request;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        internal_tx_bit, sync_seg, rx_wr_valid, rx_wr_first, rx_wr_last;
  logic [7:0]  rx_wr_data, tx_byte_data;
  logic        pin0_highside_state, pin0_lowside_state;
  logic        pin1_highside_state, pin1_lowside_state;
  logic        transmit_pin_0_o, transmit_pin_0_oe, transmit_pin_1_o, transmit_pin_1_oe;
  logic [10:0] tx_identifier;
  logic        tx_remote, rx_overrun, rx_msg_ready;
  logic [3:0]  tx_byte_count;
  logic [2:0]  tx_byte_idx;
  logic        seen_ovr = 1'b0;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;

  cod_top uut (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_request,
    .internal_tx_bit, .sync_seg, .pin0_highside_state, .pin0_lowside_state,
    .pin1_highside_state, .pin1_lowside_state, .transmit_pin_0_o, .transmit_pin_0_oe,
    .transmit_pin_1_o, .transmit_pin_1_oe, .tx_identifier, .tx_remote, .tx_byte_count,
    .tx_byte_idx, .tx_byte_data, .rx_wr_valid, .rx_wr_first, .rx_wr_last, .rx_wr_data,
    .rx_overrun, .rx_msg_ready);

  cod_node_model node (.clk_sys, .internal_tx_bit, .sync_seg, .rx_wr_valid,
    .rx_wr_first, .rx_wr_last, .rx_wr_data);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // The pulse is only one cycle wide, so remember it
  always @(posedge clk_sys) if (rx_overrun === 1'b1) seen_ovr <= 1'b1;

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    s_axi_bready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, {24'h0, d});
    chk("rresp", s_axi_rresp, er);
  endtask : rd

  // Expected transistors as {hs0, ls0, hs1, ls1}; a pin is driven when either is on
  task automatic pins(input logic [3:0] e);
    chk("drv", {pin0_highside_state, pin0_lowside_state,
                pin1_highside_state, pin1_lowside_state}, e);
    chk("pin", {transmit_pin_0_o, transmit_pin_0_oe, transmit_pin_1_o, transmit_pin_1_oe},
        {e[3], |e[3:2], e[1], |e[1:0]});
  endtask : pins

  initial begin
    logic [3:0] cf;
    logic       hs, ls;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb   = 4'h1;
    tx_byte_idx   = 3'h0;
    reset_request = 1'b0;
    reset         = 1'b1;
    repeat (10) @(posedge clk_sys);
    reset         <= 1'b0;
    reset_request <= 1'b1;
    rd(IDX_ODC, ODC_RST, RESP_OKAY);
    // Biphase first, while the toggle flop still holds its reset state
    wr(IDX_ODC, 8'hd8, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      node.send_bit(~k[0], 3);
      #1;
      pins(k == 1 ? 4'h6 : k == 3 ? 4'h9 : 4'h0);
    end
    wr(IDX_ODC, 8'hd9, RESP_OKAY);
    node.send_bit(1'b0, 3);
    #1;
    pins(4'h0);
    for (int c = 0; c < 16; c++) begin
      cf = c[3:0];
      wr(IDX_ODC, {cf[3:1], cf[3:1], MODE_NORMAL1}, RESP_OKAY);
      node.send_bit(cf[0], 3);
      #1;
      hs = cf[3] & (cf[0] ^ cf[1]);
      ls = cf[2] & ~(cf[0] ^ cf[1]);
      pins({hs, ls, hs, ls});
    end
    wr(IDX_ODC, {6'h36, MODE_NORMAL2}, RESP_OKAY);
    fork
      node.send_bit(1'b1, 4);
      begin
        repeat (2) @(posedge clk_sys);
        #1;
        pins(4'ha);
      end
    join
    #1;
    pins(4'h9);
    @(posedge clk_sys) reset_request <= 1'b0;
    wr(IDX_ODC, 8'h00, RESP_SLVERR);
    rd(IDX_ODC, 8'h00, RESP_SLVERR);
    reset_request <= 1'b1;
    rd(IDX_ODC, {6'h36, MODE_NORMAL2}, RESP_OKAY);
    wr(IDX_TX_ID_HI, 8'h5a, RESP_OKAY);
    for (int d = 0; d < 10; d++) begin
      wr(IDX_TX_CTL, {3'h5, 1'b0, d[3:0]}, RESP_OKAY);
      chk("count", tx_byte_count, d > 8 ? 8 : d);
    end
    chk("ident", tx_identifier, {8'h5a, 3'h5});
    chk("remote", tx_remote, 1'b0);
    wr(IDX_TX_CTL, 8'h15, RESP_OKAY);
    chk("remote", {tx_remote, tx_byte_count}, 5'h10);
    rd(IDX_TX_CTL, 8'h15, RESP_OKAY);
    for (int i = 0; i < 8; i++) wr(IDX_TX_DATA0 + 6'(i), 8'h30 + 8'(i), RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      rd(IDX_TX_DATA0 + 6'(i), 8'h30 + 8'(i), RESP_OKAY);
      tx_byte_idx <= 3'(7 - i);
      repeat (2) @(posedge clk_sys);
      chk("fetch", tx_byte_data, 8'h37 - 8'(i));
    end
    rd(6'h00, 8'h00, RESP_SLVERR);
    wr(IDX_RX_ID_HI, 8'h11, RESP_SLVERR);
    node.send_msg(8'ha0, 0);
    @(posedge clk_sys);
    #1;
    chk("ready", rx_msg_ready, 1'b1);
    rd(IDX_RX_ID_HI, 8'ha0, RESP_OKAY);
    rd(IDX_RX_CTL, 8'ha1, RESP_OKAY);
    rd(IDX_RX_DATA7, 8'ha9, RESP_OKAY);
    node.send_msg(8'hb0, 2);
    node.send_msg(8'hc0, 0);
    repeat (3) @(posedge clk_sys);
    chk("overrun", seen_ovr, 1'b1);
    rd(IDX_RX_STATUS, 8'h07, RESP_OKAY);
    wr(IDX_RX_STATUS, 8'h01, RESP_OKAY);
    rd(IDX_RX_ID_HI, 8'hb0, RESP_OKAY);
    wr(IDX_RX_STATUS, 8'h02, RESP_OKAY);
    rd(IDX_RX_STATUS, 8'h01, RESP_OKAY);
    test_done();
  end
endmodule : cod_tb_top

`default_nettype wire
